// file: design/adc_gain_fir_decimator.sv
// Per-channel digital gain followed by a symmetric FIR decimator.
// Samples arrive and leave on SYS_CLK; the register port is synchronous to it.
//
// Overview of operation
// - Each channel applies digital gain from 0 to 12 dB in 1 dB steps.
// - After reset every channel gain is 0 dB until software changes it.
// - Gain codes 0 to 12 map to dB directly; software keeps codes at most 12.
// - Filter decimates by 2, 4 or 8 with low, high or band-pass responses.
// - Even form: 24-tap symmetric FIR, h0..h11 mirrored, scaled by 1/2048.
// - Odd form: 23-tap symmetric FIR, centre tap h11 once, scaled by 1/2048.
// - Coefficients are 12-bit signed two's complement, -2048 to +2047.
// - Decimate-by-2 built-ins: type 0 low-pass, type 1 high-pass, odd form.
// - Decimate-by-4 built-ins: types 2..4 even form, type 5 high-pass odd.
// - Custom filters use type 0, custom enable, decimation codes 0, 1, 4.
// - Decimation code 3 with custom enable and filter use gives 12-tap mode.
// - Built-in decimate-by-2 low-pass and high-pass coefficient sets are fixed.
// - Built-in decimate-by-4 low, band-pass and high-pass sets are fixed.
// - Twelve custom coefficient registers per channel sit at 5Ah to B9h.
// - Coefficient register MSB picks built-in (0) or custom (1) coefficient.
// - Filter controls live at 29h, 2Eh, 2Fh, 30h, 31h and 38h.
// - 12-tap mode uses h6..h11 on six mirrored tap pairs, scaled by 1/2048.
// - 12-tap mode is enabled by decimation code 3 with the custom enable bit at 38h.
`default_nettype none
module adc_gain_fir_decimator
  import fir_gain_pkg::*;
#(
  parameter int NCH = CH_N,
  parameter int DW  = SAMPLE_W
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RESET_N,
  input  wire logic                       IN_VALID,
  input  wire logic [NCH-1:0][DW-1:0]     IN_DATA,
  output logic      [NCH-1:0]             OUT_VALID,
  output logic      [NCH-1:0][DW-1:0]     OUT_DATA,
  input  wire logic [ADDR_W-1:0]          REG_ADDR,
  input  wire logic [DATA_W-1:0]          REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic      [DATA_W-1:0]          REG_RDATA
);

  localparam int ACC_W  = DW + 18;
  localparam int NCOEF  = NCH * COEF_PER_CH;
  localparam int HALF   = COEF_PER_CH;
  localparam int PAIR_W = DW + 1;

  // Register layout packs two channels per filter word and four per gain word
  if (NCH != CH_N) begin : g_bad_nch
    $error("NCH must equal the register layout channel count");
  end
  if (DW < 8 || DW > 16) begin : g_bad_dw
    $error("DW must lie between 8 and 16");
  end

  typedef struct packed {
    chan_cfg_t [NCH-1:0]                    cfg;
    logic      [1:0]                        out_rate;
    logic                                   fir_en;
    coef_reg_t [NCOEF-1:0]                  coef;
    logic      [NCH-1:0][DW-1:0]            gain_data;
    logic                                   gain_valid;
    logic      [NCH-1:0][TAP_EVEN-1:0][DW-1:0] hist;
    logic                                   step;
    logic                                   hit;
    logic      [2:0]                        phase;
    logic      [NCH-1:0]                    out_valid;
    logic      [NCH-1:0][DW-1:0]            out_data;
    logic      [DATA_W-1:0]                 rdata;
  } state_t;

  state_t              st_r;
  state_t              st_nxt;
  logic   [DW-1:0]     gain_word [NCH];
  logic   [DW-1:0]     fir_word  [NCH];
  logic   [2:0]        dec_last;

  function automatic logic [DW-1:0] sat_w(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] hi_lim;
    logic signed [ACC_W-1:0] lo_lim;
    hi_lim = ACC_W'({1'b0, {(DW-1){1'b1}}});
    lo_lim = ~hi_lim;
    if (v > hi_lim) begin
      return hi_lim[DW-1:0];
    end else if (v < lo_lim) begin
      return lo_lim[DW-1:0];
    end
    return v[DW-1:0];
  endfunction

  // Codes above 12 are not legal; they fall back to unity gain
  function automatic logic [12:0] gain_q(input logic [3:0] code);
    if (code > GAIN_MAX_CODE) begin
      return GAIN_Q10[0];
    end
    return GAIN_Q10[code];
  endfunction

  function automatic logic [COEF_W-1:0] pick(input chan_cfg_t c, input coef_reg_t r,
                                             input int k);
    if (c.ucoef_en && r.sel) begin
      return r.value;
    end
    if (c.rtype <= TYPE_MAX) begin
      return BI_COEF[c.rtype][k];
    end
    return '0;
  endfunction

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic signed [ACC_W-1:0]  gain_prod;
    logic signed [ACC_W-1:0]  fir_acc;
    logic signed [ACC_W-1:0]  term;
    logic signed [PAIR_W-1:0] pair;
    logic signed [COEF_W-1:0] h;
    logic                     mode12;

    always_comb begin
      gain_prod = ACC_W'($signed(IN_DATA[g])) *
                  ACC_W'($signed({1'b0, gain_q(st_r.cfg[g].gain)}));
      gain_word[g] = sat_w(gain_prod >>> GAIN_FRAC);
    end

    always_comb begin
      mode12  = (st_r.cfg[g].dec == DEC_NONE) && st_r.cfg[g].ucoef_en;
      fir_acc = '0;
      term    = '0;
      pair    = '0;
      h       = '0;
      for (int k = 0; k < HALF; k++) begin
        h = $signed(pick(st_r.cfg[g], st_r.coef[g*COEF_PER_CH+k], k));
        if (mode12) begin
          if (k < HALF/2) begin
            h    = $signed(pick(st_r.cfg[g], st_r.coef[g*COEF_PER_CH+k+HALF/2],
                                k + HALF/2));
            pair = PAIR_W'($signed(st_r.hist[g][k])) +
                   PAIR_W'($signed(st_r.hist[g][HALF-1-k]));
          end else begin
            pair = '0;
          end
        end else if (st_r.cfg[g].odd && k == HALF-1) begin
          pair = PAIR_W'($signed(st_r.hist[g][k]));
        end else if (st_r.cfg[g].odd) begin
          pair = PAIR_W'($signed(st_r.hist[g][k])) +
                 PAIR_W'($signed(st_r.hist[g][TAP_EVEN-2-k]));
        end else begin
          pair = PAIR_W'($signed(st_r.hist[g][k])) +
                 PAIR_W'($signed(st_r.hist[g][TAP_EVEN-1-k]));
        end
        term    = ACC_W'(pair) * ACC_W'(h);
        fir_acc = fir_acc + term;
      end
      fir_word[g] = sat_w(fir_acc >>> FIR_FRAC);
    end
  end

  // Channel 0 sets the shared phase; all channels carry the same code
  always_comb begin
    case (st_r.cfg[0].dec)
      DEC_BY2: dec_last = 3'h1;
      DEC_BY4: dec_last = 3'h3;
      DEC_BY8: dec_last = 3'h7;
      default: dec_last = 3'h0;
    endcase
  end

  always_comb begin
    logic filt;
    logic [6:0] cidx;
    logic [1:0] pidx;
    filt   = 1'b0;
    cidx   = '0;
    pidx   = '0;
    st_nxt = st_r;

    // Gain stage
    st_nxt.gain_valid = IN_VALID;
    if (IN_VALID) begin
      for (int c = 0; c < NCH; c++) begin
        st_nxt.gain_data[c] = gain_word[c];
      end
    end

    // Tap history and decimation phase
    st_nxt.step = st_r.gain_valid;
    st_nxt.hit  = 1'b0;
    if (st_r.gain_valid) begin
      for (int c = 0; c < NCH; c++) begin
        st_nxt.hist[c] = {st_r.hist[c][TAP_EVEN-2:0], st_r.gain_data[c]};
      end
      st_nxt.hit   = (st_r.phase == dec_last);
      st_nxt.phase = (st_r.phase == dec_last) ? 3'h0 : st_r.phase + 3'h1;
    end

    // Output stage; unfiltered channels pass every gained sample
    for (int c = 0; c < NCH; c++) begin
      filt = st_r.fir_en && st_r.cfg[c].fir_use;
      st_nxt.out_valid[c] = st_r.step && (!filt || st_r.hit);
      if (st_r.step && (!filt || st_r.hit)) begin
        st_nxt.out_data[c] = filt ? fir_word[c] : st_r.hist[c][0];
      end
    end

    // Register writes
    if (REG_WR) begin
      if (REG_ADDR == ADDR_RATE) begin
        st_nxt.out_rate = REG_WDATA[FLD_RATE_LSB +: 2];
        st_nxt.fir_en   = REG_WDATA[FLD_FIREN_BIT];
      end else if (REG_ADDR == ADDR_GAIN_LO || REG_ADDR == ADDR_GAIN_HI) begin
        for (int i = 0; i < NCH/2; i++) begin
          st_nxt.cfg[(REG_ADDR == ADDR_GAIN_HI ? NCH/2 : 0) + i].gain =
            REG_WDATA[i*FLD_GAIN_W +: FLD_GAIN_W];
        end
      end else if (REG_ADDR >= ADDR_FILT_FRST && REG_ADDR <= ADDR_FILT_LAST) begin
        pidx = 2'(REG_ADDR - ADDR_FILT_FRST);
        for (int j = 0; j < 2; j++) begin
          st_nxt.cfg[2*pidx+j].dec     = REG_WDATA[j*FLD_CFG_W+FLD_DEC_LSB +: 3];
          st_nxt.cfg[2*pidx+j].rtype   = REG_WDATA[j*FLD_CFG_W+FLD_TYPE_LSB +: 3];
          st_nxt.cfg[2*pidx+j].odd     = REG_WDATA[j*FLD_CFG_W+FLD_ODD_BIT];
          st_nxt.cfg[2*pidx+j].fir_use = REG_WDATA[j*FLD_CFG_W+FLD_USE_BIT];
        end
      end else if (REG_ADDR == ADDR_UCOEF_EN) begin
        for (int c = 0; c < NCH; c++) begin
          st_nxt.cfg[c].ucoef_en = REG_WDATA[c];
        end
      end else if (REG_ADDR >= ADDR_COEF_FRST && REG_ADDR <= ADDR_COEF_LAST) begin
        cidx = 7'(REG_ADDR - ADDR_COEF_FRST);
        st_nxt.coef[cidx].sel   = REG_WDATA[FLD_SEL_BIT];
        st_nxt.coef[cidx].value = REG_WDATA[COEF_W-1:0];
      end
    end

    // Register reads answer in the next cycle; unmapped reads give zero
    st_nxt.rdata = '0;
    if (REG_RD) begin
      if (REG_ADDR == ADDR_RATE) begin
        st_nxt.rdata[FLD_RATE_LSB +: 2] = st_r.out_rate;
        st_nxt.rdata[FLD_FIREN_BIT]     = st_r.fir_en;
      end else if (REG_ADDR == ADDR_GAIN_LO || REG_ADDR == ADDR_GAIN_HI) begin
        for (int i = 0; i < NCH/2; i++) begin
          st_nxt.rdata[i*FLD_GAIN_W +: FLD_GAIN_W] =
            st_r.cfg[(REG_ADDR == ADDR_GAIN_HI ? NCH/2 : 0) + i].gain;
        end
      end else if (REG_ADDR >= ADDR_FILT_FRST && REG_ADDR <= ADDR_FILT_LAST) begin
        pidx = 2'(REG_ADDR - ADDR_FILT_FRST);
        for (int j = 0; j < 2; j++) begin
          st_nxt.rdata[j*FLD_CFG_W+FLD_DEC_LSB +: 3]  = st_r.cfg[2*pidx+j].dec;
          st_nxt.rdata[j*FLD_CFG_W+FLD_TYPE_LSB +: 3] = st_r.cfg[2*pidx+j].rtype;
          st_nxt.rdata[j*FLD_CFG_W+FLD_ODD_BIT]       = st_r.cfg[2*pidx+j].odd;
          st_nxt.rdata[j*FLD_CFG_W+FLD_USE_BIT]       = st_r.cfg[2*pidx+j].fir_use;
        end
      end else if (REG_ADDR == ADDR_UCOEF_EN) begin
        for (int c = 0; c < NCH; c++) begin
          st_nxt.rdata[c] = st_r.cfg[c].ucoef_en;
        end
      end else if (REG_ADDR == ADDR_STATUS) begin
        st_nxt.rdata[FLD_PHASE_LSB +: 3] = st_r.phase;
      end else if (REG_ADDR >= ADDR_COEF_FRST && REG_ADDR <= ADDR_COEF_LAST) begin
        cidx = 7'(REG_ADDR - ADDR_COEF_FRST);
        st_nxt.rdata[FLD_SEL_BIT]  = st_r.coef[cidx].sel;
        st_nxt.rdata[COEF_W-1:0]   = st_r.coef[cidx].value;
      end
    end
  end

  // All-zero reset: gain code 0 is unity, filters off, phase 0
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign OUT_VALID = st_r.out_valid;
  assign OUT_DATA  = st_r.out_data;
  assign REG_RDATA = st_r.rdata;

endmodule
`default_nettype wire

// file: design/fir_gain_pkg.sv
// Constants, register map and carrier types for the gain and FIR decimator block.
// Assumes a single sample clock shared by the conversion cores and serializers.
`default_nettype none
package fir_gain_pkg;

  localparam int CH_N        = 8;
  localparam int SAMPLE_W    = 12;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;
  localparam int COEF_W      = 12;
  localparam int COEF_PER_CH = 12;
  localparam int TAP_EVEN    = 24;
  localparam int GAIN_FRAC   = 10;
  localparam int FIR_FRAC    = 11;

  // Register addresses
  localparam logic [7:0] ADDR_RATE      = 8'h29;
  localparam logic [7:0] ADDR_GAIN_LO   = 8'h2A;
  localparam logic [7:0] ADDR_GAIN_HI   = 8'h2B;
  localparam logic [7:0] ADDR_FILT_FRST = 8'h2E;
  localparam logic [7:0] ADDR_FILT_LAST = 8'h31;
  localparam logic [7:0] ADDR_UCOEF_EN  = 8'h38;
  localparam logic [7:0] ADDR_STATUS    = 8'h3A;
  localparam logic [7:0] ADDR_COEF_FRST = 8'h5A;
  localparam logic [7:0] ADDR_COEF_LAST = 8'hB9;

  // Field positions
  localparam int FLD_RATE_LSB  = 0;
  localparam int FLD_FIREN_BIT = 2;
  localparam int FLD_GAIN_W    = 4;
  localparam int FLD_CFG_W     = 8;
  localparam int FLD_DEC_LSB   = 0;
  localparam int FLD_TYPE_LSB  = 3;
  localparam int FLD_ODD_BIT   = 6;
  localparam int FLD_USE_BIT   = 7;
  localparam int FLD_SEL_BIT   = 15;
  localparam int FLD_PHASE_LSB = 0;

  localparam logic [3:0] GAIN_MAX_CODE = 4'hC;

  // Decimation select codes and highest response select
  localparam logic [2:0] DEC_BY2  = 3'h0;
  localparam logic [2:0] DEC_BY4  = 3'h1;
  localparam logic [2:0] DEC_NONE = 3'h3;
  localparam logic [2:0] DEC_BY8  = 3'h4;
  localparam logic [2:0] TYPE_MAX = 3'h5;

  // Gain in Q10 for 0..12 dB
  localparam logic [12:0] GAIN_Q10 [0:12] = '{
    13'h0400, 13'h047D, 13'h0509, 13'h05A6, 13'h0657, 13'h071D, 13'h07FB,
    13'h08F4, 13'h0A0C, 13'h0B46, 13'h0CA6, 13'h0E31, 13'h0FED};

  // Built-in sets h0..h11 indexed by response select 0..5
  localparam logic [11:0] BI_COEF [0:5][0:11] = '{
    '{12'h003, 12'h000, 12'h005, 12'h001, 12'hFE5, 12'hFFE,
      12'h049, 12'h003, 12'hF4E, 12'hFFC, 12'h27C, 12'h400},
    '{12'hFEA, 12'hFBF, 12'hFCC, 12'h01E, 12'h042, 12'hFDD,
      12'hF95, 12'h026, 12'h0CA, 12'hFD7, 12'hD7C, 12'h425},
    '{12'hFEF, 12'hFCE, 12'h047, 12'h02E, 12'h018, 12'hFD6,
      12'hF9C, 12'hF9F, 12'h008, 12'h0CA, 12'h19E, 12'h22A},
    '{12'hFF9, 12'h013, 12'hFD1, 12'h07F, 12'h049, 12'h000,
      12'h056, 12'h075, 12'hF42, 12'hE30, 12'hF8F, 12'h20E},
    '{12'hFDE, 12'hFDE, 12'hF9B, 12'h02B, 12'h03A, 12'hFE4,
      12'hFFB, 12'hF4D, 12'h126, 12'h056, 12'hDCD, 12'h160},
    '{12'h028, 12'hFF1, 12'hFA1, 12'h016, 12'hFF8, 12'hFAF,
      12'h06A, 12'hFC2, 12'hF9F, 12'h136, 12'hE0B, 12'h23F}};

  typedef struct packed {
    logic [3:0] gain;
    logic [2:0] dec;
    logic [2:0] rtype;
    logic       odd;
    logic       fir_use;
    logic       ucoef_en;
  } chan_cfg_t;

  typedef struct packed {
    logic              sel;
    logic [COEF_W-1:0] value;
  } coef_reg_t;

endpackage
`default_nettype wire

// file: tb/gain_fir_asserts.sv
// Port-level checker for the gain and FIR block.
// Assumes one clock and bus strobes held low while in reset.
`default_nettype none
module gain_fir_asserts
  import fir_gain_pkg::*;
#(
  parameter int NCH = CH_N,
  parameter int DW  = SAMPLE_W
) (
  input wire logic                   SYS_CLK,
  input wire logic                   RESET_N,
  input wire logic                   IN_VALID,
  input wire logic [NCH-1:0][DW-1:0] IN_DATA,
  input wire logic [NCH-1:0]         OUT_VALID,
  input wire logic [NCH-1:0][DW-1:0] OUT_DATA,
  input wire logic [ADDR_W-1:0]      REG_ADDR,
  input wire logic [DATA_W-1:0]      REG_WDATA,
  input wire logic                   REG_WR,
  input wire logic                   REG_RD,
  input wire logic [DATA_W-1:0]      REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
    else $error("read data not zero outside answer");
  unmapped_zero_a: assert property (REG_RD && REG_ADDR > ADDR_COEF_LAST |=> REG_RDATA == '0)
    else $error("unmapped read not zero");
  coef_rsvd_a: assert property (REG_RD && REG_ADDR >= ADDR_COEF_FRST
    && REG_ADDR <= ADDR_COEF_LAST |=> REG_RDATA[14:12] == 3'h0)
    else $error("coefficient spare bits not zero");
  ucoef_rsvd_a: assert property (REG_RD && REG_ADDR == ADDR_UCOEF_EN |=> REG_RDATA[15:8] == 8'h00)
    else $error("user coefficient enable spare bits set");
  rate_rsvd_a: assert property (REG_RD && REG_ADDR == ADDR_RATE |=> REG_RDATA[15:3] == 13'h0)
    else $error("rate register spare bits set");
  gain_echo_a: assert property ((REG_WR && REG_ADDR == ADDR_GAIN_LO) ##2
    (REG_RD && REG_ADDR == ADDR_GAIN_LO) |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("gain code readback differs");
  out_cause_a: assert property (OUT_VALID != '0 |-> $past(IN_VALID, 3))
    else $error("output strobe without sample three cycles before");
  for (genvar c = 0; c < NCH; c++) begin : g_hold
    out_hold_a: assert property (!OUT_VALID[c] |-> $stable(OUT_DATA[c]))
      else $error("output word changed without strobe");
  end
endmodule
`default_nettype wire

// file: tb/sample_source.sv
// Stand-in for the conversion cores that feed sample sets to the block.
// Assumes each burst is started just after a rising clock edge.
`default_nettype none
module sample_source
  import fir_gain_pkg::*;
(
  input  wire logic                     SYS_CLK,
  output logic                          IN_VALID,
  output logic [CH_N-1:0][SAMPLE_W-1:0] IN_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    IN_VALID = 1'b0;
    IN_DATA  = '0;
  end
  // Idle data inverted so a stale word never looks valid
  task automatic send(input logic [CH_N-1:0][SAMPLE_W-1:0] d, input bit last);
    IN_VALID <= 1'b1;
    IN_DATA  <= d;
    @(posedge SYS_CLK);
    if (last) begin
      IN_VALID <= 1'b0;
      IN_DATA  <= ~d;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/test_adc_gain_fir_decimator.sv
// Bench for the gain and FIR block: register tasks, gain and filter tests.
// Assumes the sample source model and the bound checker.
`default_nettype none
module test_adc_gain_fir_decimator
  import fir_gain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AMP = 2047;
  logic                          SYS_CLK   = 1'b0;
  logic                          RESET_N   = 1'b0;
  logic                          IN_VALID;
  logic [CH_N-1:0][SAMPLE_W-1:0] IN_DATA;
  logic [CH_N-1:0]               OUT_VALID;
  logic [CH_N-1:0][SAMPLE_W-1:0] OUT_DATA;
  logic [ADDR_W-1:0]             REG_ADDR  = '0;
  logic [DATA_W-1:0]             REG_WDATA = '0;
  logic [DATA_W-1:0]             REG_RDATA;
  logic                          REG_WR    = 1'b0;
  logic                          REG_RD    = 1'b0;
  int                            num_errors = 0;
  int                            num_checks = 0;
  logic [SAMPLE_W-1:0]           q [CH_N][$];
  logic [7:0] ra [6] = '{ADDR_GAIN_LO, ADDR_GAIN_HI, ADDR_RATE, ADDR_UCOEF_EN,
                         ADDR_COEF_FRST, ADDR_STATUS};
  logic [2:0] md_dec [8] = '{DEC_BY2, DEC_BY2, DEC_BY4, DEC_BY4, DEC_BY4, DEC_BY4,
                             DEC_BY8, DEC_NONE};
  logic [2:0] md_typ [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0};
  bit         md_odd [8] = '{1, 1, 0, 0, 0, 1, 0, 0};
  int         md_n   [8] = '{2, 2, 4, 4, 4, 4, 8, 1};
  int bi [6][12] = '{'{3, 0, 5, 1, -27, -2, 73, 3, -178, -4, 636, 1024},
    '{-22, -65, -52, 30, 66, -35, -107, 38, 202, -41, -644, 1061},
    '{-17, -50, 71, 46, 24, -42, -100, -97, 8, 202, 414, 554},
    '{-7, 19, -47, 127, 73, 0, 86, 117, -190, -464, -113, 526},
    '{-34, -34, -101, 43, 58, -28, -5, -179, 294, 86, -563, 352},
    '{40, -15, -95, 22, -8, -81, 106, -62, -97, 310, -501, 575}};

  always #4 SYS_CLK = ~SYS_CLK;

  sample_source src (.SYS_CLK(SYS_CLK), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA));
  adc_gain_fir_decimator DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .IN_VALID(IN_VALID),
    .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

  always @(posedge SYS_CLK)
    for (int c = 0; c < CH_N; c++)
      if (OUT_VALID[c] === 1'b1) q[c].push_back(OUT_DATA[c]);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
    @(posedge SYS_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b0;
    #1 chk(REG_RDATA, e, what);
  endtask
  task automatic do_reset();
    RESET_N <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    for (int c = 0; c < CH_N; c++) q[c].delete();
  endtask
  function automatic logic [11:0] sat(int v);
    return (v > 2047) ? 12'h7FF : (v < -2048) ? 12'h800 : 12'(v);
  endfunction
  function automatic int cust(int k);
    return (k == 0) ? -2048 : (k == 11) ? 2047 : 150 * k - 900;
  endfunction
  // Weight seen at a given lag after a single impulse
  function automatic int tap(int m, int j);
    int k;
    if (m == 7) k = (j < 6) ? 6 + j : (j < 12) ? 17 - j : -1;
    else if (md_odd[m]) k = (j < 12) ? j : (j < 23) ? 22 - j : -1;
    else k = (j < 12) ? j : 23 - j;
    if (k < 0) return 0;
    if (m < 6 || (m == 6 && k == 7)) return bi[(m < 6) ? m : 0][k];
    return cust(k);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic gain_test();
    int g;
    int gh;
    int x [4] = '{1000, 2047, -2048, -1};
    logic [CH_N-1:0][SAMPLE_W-1:0] d;
    // Legal codes only; upper four channels walk the table downwards
    for (int c = 0; c <= 12; c++) begin
      wr(ADDR_GAIN_HI, {4{4'(12 - c)}});
      wr(ADDR_GAIN_LO, {4{4'(c)}});
      rd(ADDR_GAIN_LO, {4{4'(c)}}, "gain code");
      rd(ADDR_GAIN_HI, {4{4'(12 - c)}}, "gain code high");
      g  = $rtoi(1024.0 * 10.0 ** (c / 20.0) + 0.5);
      gh = $rtoi(1024.0 * 10.0 ** ((12 - c) / 20.0) + 0.5);
      for (int i = 0; i < 8; i++) d[i] = 12'(x[i % 4]);
      @(posedge SYS_CLK);
      src.send(d, 1'b1);
      repeat (4) @(posedge SYS_CLK);
      #1 for (int i = 0; i < 8; i++)
        chk(q[i].pop_front(), sat(((i < 4 ? g : gh) * x[i % 4]) >>> 10), "gain");
    end
  endtask
  task automatic filter_test();
    logic [7:0] cfg;
    logic [15:0] cw;
    for (int m = 0; m < 8; m++) begin
      @(posedge SYS_CLK);
      do_reset();
      wr(ADDR_RATE, 16'(m < 2 ? 5 : m < 6 ? 6 : m == 6 ? 7 : 4));
      cfg = {1'b1, md_odd[m], md_typ[m], md_dec[m]};
      wr(ADDR_FILT_FRST, {5'h0, md_dec[m], cfg});
      for (int p = 1; p < 4; p++) wr(8'(ADDR_FILT_FRST + p), {2{5'h0, md_dec[m]}});
      if (m > 5) begin
        wr(ADDR_UCOEF_EN, 16'h0001);
        for (int k = 0; k < 12; k++) begin
          cw = {!(m == 6 && k == 7), 3'h0, 12'(cust(k))};
          wr(8'(ADDR_COEF_FRST + k), cw);
          rd(8'(ADDR_COEF_FRST + k), cw, "coef");
        end
        if (m == 7) for (int a = 'hAE; a <= 'hB9; a++) wr(8'(a), 16'h8000);
      end
      @(posedge SYS_CLK);
      for (int i = 0; i < 24; i++) src.send({CH_N{12'(i == 0 ? AMP : 0)}}, i == 23);
      repeat (4) @(posedge SYS_CLK);
      #1 chk(16'(q[0].size()), 16'(24 / md_n[m]), "out count");
      chk(16'(q[1].size()), 16'h0018, "bypass count");
      for (int k = 0; k < 24 / md_n[m]; k++)
        chk(q[0][k], sat((tap(m, (k + 1) * md_n[m] - 1) * AMP) >>> 11), "fir");
    end
  endtask

  initial begin
    repeat (100000) @(posedge SYS_CLK);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    foreach (ra[i]) rd(ra[i], 16'h0000, "reset value");
    wr(8'hFF, 16'hFFFF);
    rd(8'hFF, 16'h0000, "unmapped");
    $display("reset test done");
    gain_test();
    $display("gain test done");
    filter_test();
    $display("filter test done");
    tally_and_finish();
  end
endmodule

bind adc_gain_fir_decimator gain_fir_asserts #(.NCH(NCH), .DW(DW)) u_asserts (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
  .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
`default_nettype wire
